// file: rtl/acdp_core.sv
/*
  Slave interpreter for the ASCII framed drive command protocol: parses
  requests byte by byte, runs reads and writes against an outside
  parameter store and queues the reply into a transmit FIFO.
  Assumes a character layer below that moves whole bytes and a parameter
  store that answers every request with exactly one response pulse.
*/
`timescale 1ns/100ps
module acdp_core
  import acdp_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RESET_N,
  // Configured station number.
  input wire logic [4:0] STATION_ID,
  // Received characters.
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  // Transmitted characters and line drive.
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_DRIVE_EN,
  // Parameter store access.
  output acdp_par_req_type PAR_REQ,
  output logic PAR_REQ_VALID,
  input wire acdp_par_rsp_type PAR_RSP,
  input wire logic PAR_RSP_VALID
);

  acdp_state_type state_q;
  logic [5:0] rx_len_q, emit_pos_q, ej, pl_chars, data_start, cnt_pos, rel;
  logic [7:0] cmd_q, st_hi_q, st_lo_q, c1_q, c2_q, sum_q, tx_sum_q;
  logic [7:0] calc_sum, got_sum, emit_byte;
  logic [15:0] word_q, base_q, err_code_q, check_err, pld_wdata;
  logic [15:0] pld_rdata, mon_rdata, word_sh;
  logic [3:0] cnt_q, n_q, idx_q, mon_count_q, rx_nib;
  logic hex_bad_q, over_q, nak_q, written_once_q, rd_ok_q, drive_q;
  logic par_valid_q, rx_start, rx_char, is_x, is_rw, cnt_ok, station_ok;
  logic cmd_known, len_ok, check_fail, pld_we, push, fifo_ready;
  logic fifo_idle, last_emit, in_sum;
  logic [2:0] pld_waddr, pld_raddr;
  acdp_par_req_type par_req_q;

  assign PAR_REQ = par_req_q;
  assign PAR_REQ_VALID = par_valid_q;
  assign TX_DRIVE_EN = drive_q;

  // Receive decode. Characters are whole 8-bit codes, no parity bit.
  assign rx_start = RX_VALID && (RX_DATA == ch_enq) &&
    (state_q == S_IDLE || state_q == S_RECV);
  assign rx_char = RX_VALID && state_q == S_RECV &&
    RX_DATA != ch_enq && RX_DATA != ch_eot;
  assign rx_nib = hex_to_nib(RX_DATA);
  assign is_x = (cmd_q == cmd_mon_reg);
  assign is_rw = (cmd_q == cmd_read) || (cmd_q == cmd_write);
  assign data_start = is_x ? pos_data_mon : pos_data_rw;
  assign cnt_pos = is_x ? pos_cnt_mon : pos_cnt_rw;
  assign rel = rx_len_q - data_start;

  // Request capture. ENQ mid-frame restarts, so a torn frame is dropped.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx_len_q <= '0;
      sum_q <= '0;
      c1_q <= '0;
      c2_q <= '0;
      st_hi_q <= '0;
      st_lo_q <= '0;
      cmd_q <= '0;
      cnt_q <= '0;
      base_q <= '0;
      word_q <= '0;
      hex_bad_q <= 1'b0;
      over_q <= 1'b0;
    end
    else if (rx_start)
    begin
      rx_len_q <= '0;
      sum_q <= '0;
      cmd_q <= '0;
      cnt_q <= '0;
      hex_bad_q <= 1'b0;
      over_q <= 1'b0;
    end
    else if (rx_char)
    begin
      if (rx_len_q != 6'h3f)
      begin
        rx_len_q <= rx_len_q + 6'h01;
      end
      sum_q <= sum_q + RX_DATA;
      c1_q <= c2_q;
      c2_q <= RX_DATA;
      if (rx_len_q == 6'h00)
      begin
        st_hi_q <= RX_DATA;
      end
      if (rx_len_q == 6'h01)
      begin
        st_lo_q <= RX_DATA;
      end
      if (rx_len_q == pos_cmd)
      begin
        cmd_q <= RX_DATA;
      end
      if (rx_len_q != pos_cmd && !is_hex(RX_DATA))
      begin
        hex_bad_q <= 1'b1;
      end
      if (rx_len_q >= tx_buf_len - len_frame_ctl)
      begin
        over_q <= 1'b1;
      end
      if (is_rw && rx_len_q >= pos_addr && rx_len_q < pos_cnt_rw)
      begin
        base_q <= {base_q[11:0], rx_nib};
      end
      if (rx_len_q == cnt_pos)
      begin
        cnt_q <= rx_nib;
      end
      word_q <= {word_q[11:0], rx_nib};
    end
  end

  // Frame checks, worked out while the machine sits in S_CHECK.
  assign calc_sum = sum_q - c1_q - c2_q;
  assign got_sum = {hex_to_nib(c1_q), hex_to_nib(c2_q)};
  assign station_ok = is_hex(st_hi_q) && is_hex(st_lo_q) &&
    rx_len_q > pos_cmd && STATION_ID >= station_min &&
    {hex_to_nib(st_hi_q), hex_to_nib(st_lo_q)} ==
    {3'h0, STATION_ID};
  assign cnt_ok = cnt_q >= 4'h1 && cnt_q <= max_words;
  assign cmd_known = is_rw || is_x || cmd_q == cmd_mon_read;
  always_comb
  begin
    unique case (cmd_q)
      cmd_read: len_ok = cnt_ok &&
        rx_len_q == len_read_req - len_frame_ctl;
      cmd_write: len_ok = cnt_ok && rx_len_q ==
        len_write_base - len_frame_ctl + {cnt_q, 2'b00};
      cmd_mon_reg: len_ok = cnt_ok && rx_len_q ==
        len_mon_reg_base - len_frame_ctl + {cnt_q, 2'b00};
      default: len_ok = rx_len_q == len_mon_read - len_frame_ctl;
    endcase
  end

  // Bad sums, bad characters and overruns beat an unknown command, since the command
  // character itself may be the corrupted one; a bad length loses to it.
  always_comb
  begin
    check_fail = 1'b1;
    check_err = err_frame;
    if (hex_bad_q || over_q || calc_sum != got_sum)
    begin
      check_err = err_frame;
    end
    else if (!cmd_known)
    begin
      check_err = err_unknown_func;
    end
    else if (!len_ok)
    begin
      check_err = err_frame;
    end
    else
    begin
      check_fail = 1'b0;
    end
  end

  // Word buffer port: request words while receiving, results later.
  always_comb
  begin
    pld_we = 1'b0;
    pld_waddr = rel[4:2];
    pld_wdata = {word_q[11:0], rx_nib};
    if (state_q == S_RECV)
    begin
      pld_we = rx_char && rx_len_q >= data_start && rel[1:0] == 2'b11 &&
        rel[5:2] < max_words;
    end
    else if (state_q == S_WAIT && PAR_RSP_VALID &&
      PAR_RSP.status == par_ok && !(cmd_q == cmd_write && written_once_q))
    begin
      pld_we = 1'b1;
      pld_waddr = idx_q[2:0];
      pld_wdata = PAR_RSP.rdata;
    end
  end
  assign ej = emit_pos_q - pos_reply_data;
  assign pld_raddr = (state_q == S_EMIT) ? ej[4:2] : idx_q[2:0];

  acdp_mem #(.WIDTH(word_width), .DEPTH(mon_depth)) u_payload (
    .clk(MCLK),
    .reset_n(RESET_N),
    .we(pld_we),
    .waddr(pld_waddr),
    .wdata(pld_wdata),
    .raddr(pld_raddr),
    .rdata_q(pld_rdata)
  );

  // Monitor list, filled only after a whole registration checks out.
  acdp_mem #(.WIDTH(word_width), .DEPTH(mon_depth)) u_monitor (
    .clk(MCLK),
    .reset_n(RESET_N),
    .we(state_q == S_COPY && rd_ok_q),
    .waddr(idx_q[2:0]),
    .wdata(pld_rdata),
    .raddr(idx_q[2:0]),
    .rdata_q(mon_rdata)
  );

  // Reply character selection.
  assign pl_chars = nak_q ? 6'h02 : (is_x ? 6'h00 : {n_q, 2'b00});
  assign word_sh = pld_rdata >> {~ej[1:0], 2'b00};
  assign last_emit = (emit_pos_q == pos_reply_data + pl_chars + 6'h02);
  assign in_sum = emit_pos_q != 6'h00 && emit_pos_q < pos_reply_data + pl_chars;
  always_comb
  begin
    if (emit_pos_q == 6'h00)
    begin
      emit_byte = nak_q ? ch_nak : ch_ack;
    end
    else if (emit_pos_q == 6'h01)
    begin
      emit_byte = st_hi_q;
    end
    else if (emit_pos_q == 6'h02)
    begin
      emit_byte = st_lo_q;
    end
    else if (emit_pos_q == 6'h03)
    begin
      emit_byte = cmd_q;
    end
    else if (emit_pos_q < pos_reply_data + pl_chars)
    begin
      if (nak_q)
      begin
        emit_byte = ej[0] ? err_code_q[7:0] : err_code_q[15:8];
      end
      else
      begin
        emit_byte = nib_to_hex(word_sh[3:0]);
      end
    end
    else if (emit_pos_q == pos_reply_data + pl_chars)
    begin
      emit_byte = nib_to_hex(tx_sum_q[7:4]);
    end
    else if (!last_emit)
    begin
      emit_byte = nib_to_hex(tx_sum_q[3:0]);
    end
    else
    begin
      emit_byte = ch_eot;
    end
  end
  assign push = state_q == S_EMIT && rd_ok_q && fifo_ready;

  // Reply checksum over station, command and payload characters.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tx_sum_q <= '0;
    end
    else if (state_q != S_EMIT)
    begin
      tx_sum_q <= '0;
    end
    else if (push && in_sum)
    begin
      tx_sum_q <= tx_sum_q + emit_byte;
    end
  end

  // Command sequencing. Reads of either word store need one settled
  // cycle, so every step drops rd_ok_q for a clock.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= S_IDLE;
      idx_q <= '0;
      n_q <= '0;
      mon_count_q <= '0;
      nak_q <= 1'b0;
      err_code_q <= err_frame;
      emit_pos_q <= '0;
      written_once_q <= 1'b0;
      rd_ok_q <= 1'b0;
      par_valid_q <= 1'b0;
      par_req_q <= '0;
    end
    else
    begin
      rd_ok_q <= 1'b1;
      par_valid_q <= 1'b0;
      unique case (state_q)
        S_IDLE, S_RECV:
        begin
          if (rx_start)
          begin
            state_q <= S_RECV;
          end
          else if (state_q == S_RECV && RX_VALID && RX_DATA == ch_eot)
          begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          idx_q <= '0;
          emit_pos_q <= '0;
          rd_ok_q <= 1'b0;
          nak_q <= check_fail;
          err_code_q <= check_err;
          n_q <= (cmd_q == cmd_mon_read) ? mon_count_q : cnt_q;
          if (!station_ok)
          begin
            state_q <= S_IDLE;
          end
          else if (check_fail || (cmd_q == cmd_mon_read &&
            mon_count_q == 4'h0))
          begin
            state_q <= S_EMIT;
          end
          else
          begin
            state_q <= is_x ? S_COPY : S_REQ;
          end
        end
        S_COPY:
        begin
          if (rd_ok_q)
          begin
            idx_q <= idx_q + 4'h1;
            rd_ok_q <= 1'b0;
            if (idx_q + 4'h1 == n_q)
            begin
              mon_count_q <= n_q;
              state_q <= S_EMIT;
            end
          end
        end
        S_REQ:
        begin
          if (rd_ok_q)
          begin
            par_valid_q <= 1'b1;
            par_req_q.we <= (cmd_q == cmd_write);
            par_req_q.wdata <= pld_rdata;
            par_req_q.addr <= (cmd_q == cmd_mon_read) ? mon_rdata :
              base_q + {12'h000, idx_q};
            state_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (PAR_RSP_VALID)
          begin
            rd_ok_q <= 1'b0;
            if (PAR_RSP.status != par_ok)
            begin
              nak_q <= 1'b1;
              unique case (PAR_RSP.status)
                par_bad_value: err_code_q <= err_invalid_value;
                par_refused: err_code_q <= err_write_refused;
                default: err_code_q <= err_invalid_address;
              endcase
              state_q <= S_EMIT;
            end
            else if (idx_q + 4'h1 == n_q)
            begin
              state_q <= S_EMIT;
            end
            else
            begin
              idx_q <= idx_q + 4'h1;
              state_q <= S_REQ;
            end
          end
        end
        S_EMIT:
        begin
          if (push)
          begin
            emit_pos_q <= emit_pos_q + 6'h01;
            rd_ok_q <= 1'b0;
            if (last_emit)
            begin
              state_q <= S_IDLE;
              if (!nak_q && cmd_q == cmd_write)
              begin
                written_once_q <= 1'b1;
              end
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  acdp_fifo #(.WIDTH(char_width), .DEPTH(fifo_depth)) u_tx_fifo (
    .clk(MCLK),
    .reset_n(RESET_N),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(emit_byte),
    .out_valid_q(TX_VALID),
    .out_ready(TX_READY),
    .out_data_q(TX_DATA),
    .idle(fifo_idle)
  );

  // The shared line is only claimed while a reply is being built or sent.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      drive_q <= 1'b0;
    end
    else
    begin
      drive_q <= (state_q == S_EMIT) || !fifo_idle;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_req_pulse;
    PAR_REQ_VALID ##1 !PAR_REQ_VALID;
  endsequence

  frame_open_a: assert property (rx_start |=> state_q == S_RECV)
    else $error("ENQ did not open a frame");
  // The line is claimed two clocks before the lead character shows, so
  // the first character seen on the pins after the claim is checked.
  lead_byte_a: assert property (
    $rose(TX_DRIVE_EN) |-> ##2 TX_VALID &&
    (TX_DATA == ch_ack || TX_DATA == ch_nak))
    else $error("Reply lead byte wrong");
  nak_length_a: assert property (
    push && nak_q && last_emit |-> emit_pos_q == len_nak - 6'h01)
    else $error("Refusal frame is not nine bytes");
  ack_length_a: assert property (
    push && !nak_q && last_emit |->
    emit_pos_q + 6'h01 == len_ack_base + pl_chars &&
    emit_pos_q < rx_buf_len)
    else $error("Positive reply length wrong");
  reply_end_a: assert property (
    push && last_emit |-> emit_byte == ch_eot ##1 state_q == S_IDLE)
    else $error("Reply did not end with EOT");
  sum_char_a: assert property (
    push && !last_emit && emit_pos_q == pos_reply_data + pl_chars |->
    emit_byte == nib_to_hex(tx_sum_q[7:4]))
    else $error("Reply checksum character wrong");
  err_print_a: assert property (
    push && nak_q && in_sum && emit_pos_q > 6'h03 |->
    emit_byte >= err_char_min && emit_byte <= err_char_max)
    else $error("Error code character not printable");
  foreign_quiet_a: assert property (
    state_q == S_CHECK && !station_ok |=> state_q == S_IDLE)
    else $error("Reply to another station");
  unknown_cmd_a: assert property (
    state_q == S_CHECK && station_ok && check_fail &&
    check_err == err_unknown_func |=> state_q == S_EMIT && nak_q &&
    err_code_q == err_unknown_func)
    else $error("Unknown command not refused");
  bad_sum_a: assert property (
    state_q == S_CHECK && station_ok && calc_sum != got_sum |=>
    nak_q && err_code_q == err_frame)
    else $error("Checksum error not refused");
  par_pulse_a: assert property (
    state_q == S_REQ && rd_ok_q |=> s_req_pulse)
    else $error("Parameter request not a single pulse");
  mon_depth_a: assert property (mon_count_q <= max_words)
    else $error("Monitor list over eight entries");

endmodule

// file: shared/acdp_pkg.sv
/*
  Shared constants, types and character helpers for the ASCII drive
  command protocol slave. Assumes a byte-wide character stream below it
  and a word-wide parameter store outside it.
*/
package acdp_pkg;

  // Framing control bytes; none of them enters the checksum.
  localparam logic [7:0] ch_enq = 8'h05;
  localparam logic [7:0] ch_eot = 8'h04;
  localparam logic [7:0] ch_ack = 8'h06;
  localparam logic [7:0] ch_nak = 8'h15;

  // Command characters.
  localparam logic [7:0] cmd_read = 8'h52;
  localparam logic [7:0] cmd_write = 8'h57;
  localparam logic [7:0] cmd_mon_reg = 8'h58;
  localparam logic [7:0] cmd_mon_read = 8'h59;

  // Two-character error codes, first character in the upper byte.
  localparam logic [15:0] err_unknown_func = 16'h4946;
  localparam logic [15:0] err_invalid_address = 16'h4941;
  localparam logic [15:0] err_invalid_value = 16'h4944;
  localparam logic [15:0] err_write_refused = 16'h574d;
  localparam logic [15:0] err_frame = 16'h4645;
  localparam logic [7:0] err_char_min = 8'h20;
  localparam logic [7:0] err_char_max = 8'h7f;

  // Frame lengths in bytes, control bytes included.
  localparam logic [5:0] len_frame_ctl = 6'h02;
  localparam logic [5:0] len_read_req = 6'h0c;
  localparam logic [5:0] len_write_base = 6'h0c;
  localparam logic [5:0] len_mon_reg_base = 6'h08;
  localparam logic [5:0] len_mon_read = 6'h07;
  localparam logic [5:0] len_nak = 6'h09;
  localparam logic [5:0] len_ack_base = 6'h07;
  localparam logic [5:0] rx_buf_len = 6'h27;
  localparam logic [5:0] tx_buf_len = 6'h2c;

  // Character positions, counted after the lead byte in a request and from it (as 0) in a reply.
  localparam logic [5:0] pos_cmd = 6'h02;
  localparam logic [5:0] pos_addr = 6'h03;
  localparam logic [5:0] pos_cnt_rw = 6'h07;
  localparam logic [5:0] pos_data_rw = 6'h08;
  localparam logic [5:0] pos_cnt_mon = 6'h03;
  localparam logic [5:0] pos_data_mon = 6'h04;
  localparam logic [5:0] pos_reply_data = 6'h04;

  // Station range and word counts.
  localparam logic [4:0] station_min = 5'h01;
  localparam logic [4:0] station_max = 5'h1f;
  localparam logic [3:0] max_words = 4'h8;
  localparam int mon_depth = 8;
  localparam int fifo_depth = 16;
  localparam int char_width = 8;
  localparam int word_width = 16;

  // Answer codes of the parameter store.
  localparam logic [1:0] par_ok = 2'h0;
  localparam logic [1:0] par_bad_addr = 2'h1;
  localparam logic [1:0] par_bad_value = 2'h2;
  localparam logic [1:0] par_refused = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_CHECK = 3'b010,
    S_COPY = 3'b011,
    S_REQ = 3'b100,
    S_WAIT = 3'b101,
    S_EMIT = 3'b110
  } acdp_state_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acdp_par_req_type;

  typedef struct packed {
    logic [1:0] status;
    logic [15:0] rdata;
  } acdp_par_rsp_type;

  // True for '0'..'9' and 'A'..'F'.
  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  // ASCII-hex character to nibble; junk maps to a harmless value.
  function automatic logic [3:0] hex_to_nib(input logic [7:0] c);
    hex_to_nib = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0];
  endfunction

  // Nibble to upper-case ASCII-hex character.
  function automatic logic [7:0] nib_to_hex(input logic [3:0] n);
    nib_to_hex = (n > 4'h9) ? 8'(8'h37 + {4'h0, n}) : {4'h3, n};
  endfunction

endpackage

// file: rtl/acdp_mem.sv
/*
  Small word store with one write port and a registered read port.
  Assumes the caller waits one clock after changing the read address.
*/
`timescale 1ns/100ps
module acdp_mem
  import acdp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Write port.
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port.
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // The array holds no reset so that it maps onto plain storage.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // Read data always come out of a register.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule

// file: rtl/acdp_fifo.sv
/*
  Synchronous FIFO with a registered output stage and valid/ready on
  both sides. Assumes one clock for writer and reader.
*/
`timescale 1ns/100ps
module acdp_fifo
  import acdp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid_q,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data_q,
  // Nothing stored and nothing offered.
  output logic idle
);

  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] count_q;
  logic push, pop;

  // Full refuses the writer, which stalls the reply builder.
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_q != '0) && (!out_valid_q || out_ready);
  assign idle = (count_q == '0) && !out_valid_q;

  // Storage write.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers, fill level and output stage.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
        out_data_q <= mem_q[rd_q];
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_q <= 1'b0;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// file: dv/acdp_store.sv
/*
  Parameter store model that sits behind the protocol core. It assumes one
  request pulse per access and answers each one two cycles later.
*/
`timescale 1ns/100ps
module acdp_store
  import acdp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Request and answer.
  input wire acdp_par_req_type req,
  input wire logic req_valid,
  output acdp_par_rsp_type rsp,
  output logic rsp_valid
);
  logic [15:0] mem [16];
  logic busy_q;

  // The answer is a cycle slower than needed, so a lazy core is caught.
  // A write returns the word that stood before it.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      for (int i = 0; i < 16; i++)
        mem[i] <= 16'h0a00 + 16'(i);
    end
    else
    begin
      busy_q <= req_valid;
      rsp_valid <= busy_q;
      if (busy_q)
      begin
        rsp.rdata <= mem[req.addr[3:0]];
        if (req.addr[15:12] != 4'h3)
          rsp.status <= (req.we && req.addr == 16'h0000) ? par_refused :
                        par_bad_addr;
        else if (req.we && req.wdata == 16'hffff)
          rsp.status <= par_bad_value;
        else
        begin
          rsp.status <= par_ok;
          if (req.we)
            mem[req.addr[3:0]] <= req.wdata;
        end
      end
    end
endmodule

// file: dv/test_ascii_drive_command_protocol.sv
/*
  Self-checking bench for the protocol core. It assumes the store model
  behind the core and a line that takes every reply character at once.
*/
`timescale 1ns/100ps
module test_ascii_drive_command_protocol
  import acdp_pkg::*;
;
  logic mclk, reset_n, rx_valid, tx_valid, tx_drive_en, req_valid, rsp_valid;
  logic [7:0] rx_data, tx_data;
  acdp_par_req_type req;
  acdp_par_rsp_type rsp;
  int err_total = 0;
  int checks = 0;
  string seen;
  logic drove;

  // Free-running clock at 10 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  acdp_core u_acdp_core (.MCLK(mclk), .RESET_N(reset_n), .STATION_ID(5'h01),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(1'b1), .TX_DRIVE_EN(tx_drive_en),
    .PAR_REQ(req), .PAR_REQ_VALID(req_valid), .PAR_RSP(rsp),
    .PAR_RSP_VALID(rsp_valid));
  acdp_store u_acdp_store (.clk(mclk), .reset_n(reset_n), .req(req),
    .req_valid(req_valid), .rsp(rsp), .rsp_valid(rsp_valid));

  // Every character taken from the core is added to the reply text, and
  // any cycle with the shared line claimed is remembered.
  always @(posedge mclk)
  begin
    if (tx_valid === 1'b1)
      seen = $sformatf("%s%c", seen, tx_data);
    if (tx_drive_en === 1'b1)
      drove = 1'b1;
  end

  // Two upper-case hex characters for the low byte of a sum.
  function automatic string hex2(int v);
    string d;
    d = "0123456789ABCDEF";
    return $sformatf("%c%c", d[v[7:4]], d[v[3:0]]);
  endfunction

  // Whole frame text; a nonzero bias spoils the sum on purpose.
  function automatic string frm(byte lead, string body, int bias);
    int s;
    s = bias;
    for (int i = 0; i < body.len(); i++)
      s += body[i];
    return $sformatf("%c%s%s%c", lead, body, hex2(s), ch_eot);
  endfunction

  task automatic cmp_str(string what, string exp, string got);
    checks++;
    if (exp != got)
    begin
      err_total++;
      $display("ERROR %s expected %s seen %s", what, exp, got);
    end
  endtask

  // Sends one request, then waits until the line is released again.
  // A silent station still gets twenty cycles to misbehave.
  task automatic xfer(string body, int bias, string exp);
    string f;
    string drv_state;
    f = frm(ch_enq, body, bias);
    seen = "";
    drove = 1'b0;
    for (int i = 0; i < f.len(); i++)
    begin
      @(negedge mclk);
      rx_data = f[i];
      rx_valid = 1'b1;
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    for (int n = 0; n < 400 && tx_drive_en !== 1'b0 || n < 20; n++)
      @(negedge mclk);
    // A line still claimed here is a hang and must not pass.
    drv_state = (tx_drive_en !== 1'b0) ? "stuck" : (drove ? "used" : "idle");
    cmp_str(body, exp, seen);
    cmp_str("line drive", (exp == "") ? "idle" : "used", drv_state);
  endtask

  task automatic t_read;
    xfer("01R30002", 0, frm(ch_ack, "01R0A000A01", 0));
    xfer("01R50001", 0, frm(ch_nak, "01RIA", 0));
  endtask

  task automatic t_write;
    xfer("01W300111234", 0, frm(ch_ack, "01W0A01", 0));
    xfer("01W300115678", 0, frm(ch_ack, "01W5678", 0));
    xfer("01W30011FFFF", 0, frm(ch_nak, "01WID", 0));
    xfer("01W000011111", 0, frm(ch_nak, "01WWM", 0));
  endtask

  task automatic t_mon;
    xfer("01X230013000", 0, frm(ch_ack, "01X", 0));
    xfer("01Y", 0, frm(ch_ack, "01Y56780A00", 0));
  endtask

  task automatic t_err;
    xfer("01Q", 0, frm(ch_nak, "01QIF", 0));
    xfer("01R30001", 1, frm(ch_nak, "01RFE", 0));
    xfer("01R30009", 0, frm(ch_nak, "01RFE", 0));
    xfer("02R30001", 0, "");
  endtask

  task automatic print_verdict;
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a tenth of this span.
  initial
  begin
    #2000000;
    err_total++;
    print_verdict();
  end

  // Reset for three cycles, then the scenarios in order of stored state.
  initial
  begin
    reset_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    t_read();
    t_write();
    t_mon();
    t_err();
    print_verdict();
  end
endmodule
